// >>> dad_consts.svh
// constants for the debug apb address decoder
`ifndef DAD_CONSTS_SVH
`define DAD_CONSTS_SVH
`define DAD_MAX_CORES       4
`define DAD_OFFSET_WIDTH    12
`define DAD_COMP_BIT        12
`define DAD_CORE_LSB        13
`define DAD_ADDR_W_ONE      13
`define DAD_ADDR_W_TWO      14
`define DAD_ADDR_W_FOUR     15
`define DAD_ADDR_WIDTH      15
`define DAD_DATA_WIDTH      32
`define DAD_CORE_CODE_THREE 2'h3
`endif

// >>> dad_pkg.sv
// types for the debug apb address decoder
package dad_pkg;
  typedef enum logic [1:0] {
    DAD_IDLE   = 2'b00,
    DAD_SETUP  = 2'b01,
    DAD_ACCESS = 2'b10
  } dad_phase_t;
  typedef enum logic {
    DAD_COMP_DEBUG   = 1'b0,
    DAD_COMP_MONITOR = 1'b1
  } dad_comp_t;
endpackage

// >>> dad_decoder.sv
// debug apb slave port decoder steering accesses to per-core components
`timescale 1ns/1ps
`default_nettype none
`include "dad_consts.svh"
// Overview of operation
// - each core has a debug and a monitor component of 4KB each, forming one 8KB region.
// - a single debug apb slave port reaches the debug resources of every core.
// - the port spans 8KB per core and answers only while debug_port_select is high.
// - address bit 12 picks the debug component when 0 and the monitor when 1.
// - with one core the address is bits 12 to 0 and no core bits are decoded.
// - with two cores bit 13 selects core 0 or core 1.
// - with three or four cores bits 14 to 13 select cores 0, 1 and 2 by codes 00, 01, 10.
// - with four cores code 11 on bits 14 to 13 selects core 3.
// - each core's debug interface is reachable on its own, independent of the others.
// - the halt trigger output, core powered up input and os lock init input are absent.
// - each core's debug logic has its own active-low reset, also gated with the shared cluster reset reset_n.
module dad_decoder
  import dad_pkg::*;
#(
  parameter int NUM_CORES = 4
) (
  // clock and reset
  input  wire  logic                            clk,
  input  wire  logic                            reset_n,
  // per-core debug logic resets, from the system
  input  wire  logic [NUM_CORES-1:0]            debug_logic_reset_n,
  // debug apb slave port, same clock as clk
  input  wire  logic                            debug_port_select,
  input  wire  logic                            penable,
  input  wire  logic                            pwrite,
  input  wire  logic [`DAD_ADDR_WIDTH-1:0]      debug_port_address,
  input  wire  logic [`DAD_DATA_WIDTH-1:0]      pwdata,
  output var   logic [`DAD_DATA_WIDTH-1:0]      prdata,
  output var   logic                            pready,
  output var   logic                            pslverr,
  // per-core component selects, then strobes, offset and write data shared by all cores
  output var   logic [NUM_CORES-1:0]            core_dbg_sel,
  output var   logic [NUM_CORES-1:0]            core_mon_sel,
  output var   logic                            comp_enable,
  output var   logic                            comp_write,
  output var   logic [`DAD_OFFSET_WIDTH-1:0]    comp_offset,
  output var   logic [`DAD_DATA_WIDTH-1:0]      comp_wdata,
  // per-core debug resets, gated with the cluster reset
  output var   logic [NUM_CORES-1:0]            core_debug_reset_n,
  // answers from the components
  input  wire  logic [NUM_CORES*`DAD_DATA_WIDTH-1:0] comp_rdata,
  input  wire  logic [NUM_CORES-1:0]            comp_ready
  // halt trigger, powered-up and os lock init ports are deliberately absent
);

  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic       rst_n;
  dad_phase_t bus_phase;
  logic [1:0] core_idx;
  logic       core_ok;
  logic       comp_bit;
  logic       sel_any;
  logic [`DAD_DATA_WIDTH-1:0] rdata_mux;
  logic       ready_mux;

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // core index from the configured address width
  always_comb begin
    if (NUM_CORES == 1) begin
      core_idx = 2'h0;
    end else if (NUM_CORES == 2) begin
      core_idx = {1'b0, debug_port_address[`DAD_CORE_LSB]};
    end else begin
      core_idx = debug_port_address[`DAD_CORE_LSB+1:`DAD_CORE_LSB];
    end
  end
  // code 11 in a three-core build addresses nothing; flagged as error
  assign core_ok  = (32'(core_idx) < NUM_CORES);
  assign comp_bit = debug_port_address[`DAD_COMP_BIT];
  assign sel_any  = debug_port_select && core_ok;

  // one-hot selects per core, each core decoded on its own
  always_comb begin
    for (int i = 0; i < NUM_CORES; i++) begin
      core_dbg_sel[i] = sel_any && (32'(core_idx) == i) && !comp_bit;
      core_mon_sel[i] = sel_any && (32'(core_idx) == i) && comp_bit;
    end
  end

  // shared apb strobes and offset fan out to all cores
  assign comp_enable = penable;
  assign comp_write  = pwrite;
  assign comp_offset = debug_port_address[`DAD_OFFSET_WIDTH-1:0];
  assign comp_wdata  = pwdata;

  // per-core debug resets also drop with the synchronised cluster reset rst_n
  always_comb begin
    for (int i = 0; i < NUM_CORES; i++) begin
      core_debug_reset_n[i] = debug_logic_reset_n[i] && rst_n;
    end
  end

  // answer mux from the addressed core
  always_comb begin
    rdata_mux = '0;
    ready_mux = 1'b1;
    for (int i = 0; i < NUM_CORES; i++) begin
      if (32'(core_idx) == i) begin
        rdata_mux = comp_rdata[i*`DAD_DATA_WIDTH +: `DAD_DATA_WIDTH];
        ready_mux = comp_ready[i];
      end
    end
  end

  // apb phase of this cycle, read straight off the strobes
  // a registered copy would lag one cycle and misplace zero-wait transfers
  always_comb begin
    bus_phase = DAD_IDLE;
    if (debug_port_select) begin
      bus_phase = penable ? DAD_ACCESS : DAD_SETUP;
    end
  end

  // handshake combinational, bad core answers at once with error
  assign pready  = debug_port_select && penable && (core_ok ? ready_mux : 1'b1);
  assign pslverr = debug_port_select && penable && !core_ok;

  // read data taken only at the completing edge; wait states leave it cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (bus_phase == DAD_SETUP) begin
      prdata <= '0;
    end else if (bus_phase == DAD_ACCESS && sel_any && pready && !pwrite) begin
      prdata <= rdata_mux;
    end
  end

  // outputs select exactly one component while a valid access is up
  property p_onehot_sel;
    @(posedge clk) disable iff (!rst_n)
      sel_any |-> $onehot({core_dbg_sel, core_mon_sel});
  endproperty
  a_onehot_sel: assert property (p_onehot_sel) else $error("select not one-hot");

  property p_no_sel_idle;
    @(posedge clk) disable iff (!rst_n)
      !debug_port_select |-> (core_dbg_sel == '0) && (core_mon_sel == '0);
  endproperty
  a_no_sel_idle: assert property (p_no_sel_idle) else $error("select without port select");

  property p_comp_bit;
    @(posedge clk) disable iff (!rst_n)
      sel_any |-> ((|core_mon_sel) == debug_port_address[`DAD_COMP_BIT]);
  endproperty
  a_comp_bit: assert property (p_comp_bit) else $error("component bit misdecoded");

  property p_offset;
    @(posedge clk) disable iff (!rst_n)
      debug_port_select |-> comp_offset == debug_port_address[11:0];
  endproperty
  a_offset: assert property (p_offset) else $error("offset altered");

  property p_core_pick;
    @(posedge clk) disable iff (!rst_n)
      (sel_any && NUM_CORES > 2) |->
        ((core_dbg_sel | core_mon_sel) == (NUM_CORES)'(1 << debug_port_address[14:13]));
  endproperty
  a_core_pick: assert property (p_core_pick) else $error("core misdecoded");

  property p_read_data;
    @(posedge clk) disable iff (!rst_n)
      (bus_phase == DAD_ACCESS && sel_any && pready && !pwrite) |=>
        (prdata == $past(rdata_mux));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not captured");

  property p_setup_clear;
    @(posedge clk) disable iff (!rst_n)
      (bus_phase == DAD_SETUP) |=> (prdata == '0);
  endproperty
  a_setup_clear: assert property (p_setup_clear) else $error("stale read data");

  property p_two_core;
    @(posedge clk) disable iff (!rst_n)
      (sel_any && NUM_CORES == 2) |->
        ((core_dbg_sel | core_mon_sel) == (NUM_CORES)'(1 << debug_port_address[13]));
  endproperty
  a_two_core: assert property (p_two_core) else $error("two-core pick wrong");

  property p_one_core;
    @(posedge clk) disable iff (!rst_n)
      (sel_any && NUM_CORES == 1) |-> ((core_dbg_sel | core_mon_sel) == (NUM_CORES)'(1));
  endproperty
  a_one_core: assert property (p_one_core) else $error("single core not picked");

  property p_err_ready;
    @(posedge clk) disable iff (!rst_n)
      pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  property p_no_err_legal;
    @(posedge clk) disable iff (!rst_n)
      (debug_port_select && core_ok) |-> !pslverr;
  endproperty
  a_no_err_legal: assert property (p_no_err_legal) else $error("legal core errored");

  property p_bad_core_err;
    @(posedge clk) disable iff (!rst_n)
      (debug_port_select && penable && !core_ok) |-> pready && pslverr;
  endproperty
  a_bad_core_err: assert property (p_bad_core_err) else $error("illegal core not errored");

  property p_dbg_reset;
    @(posedge clk) disable iff (!rst_n)
      core_debug_reset_n == debug_logic_reset_n;
  endproperty
  a_dbg_reset: assert property (p_dbg_reset) else $error("debug reset not passed");

endmodule
`default_nettype wire

// >>> dad_master.sv
// apb debug master model driving the decoder's slave port
`timescale 1ns/1ps
`default_nettype none
module dad_master (
  // clock
  input  wire logic        clk,
  // apb request
  output var  logic        sel,
  output var  logic        en,
  output var  logic        wr,
  output var  logic [14:0] addr,
  output var  logic [31:0] wdata,
  // apb answer
  input  wire logic        ready,
  input  wire logic        err,
  input  wire logic [31:0] rdata
);
  // idle bus, address parked on a pattern so no stale value looks valid
  initial begin
    sel = 1'b0;
    en = 1'b0;
    wr = 1'b0;
    addr = 15'h5555;
    wdata = 32'haaaa_5555;
  end
  // one apb transfer, held until ready is seen at a rising edge
  // callers keep code 11 on bits 14 to 13 away from a three-core build
  task automatic xfer(input logic w, input logic [14:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int   n;
    logic done;
    n = 0;
    @(negedge clk);
    sel = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    en = 1'b1;
    @(posedge clk);
    while (ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    // a transfer that never completes hands back unknowns, so the caller's compare fails
    done = (ready === 1'b1);
    e = done ? err : 1'bx;
    @(negedge clk);
    q = done ? rdata : 32'hxxxx_xxxx; // read data lands one cycle after ready
    sel = 1'b0;
    en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> debug_apb_address_decoder_bench.sv
// testbench for the debug apb address decoder
`timescale 1ns/1ps
`default_nettype none
module debug_apb_address_decoder_bench;
  logic         clk, reset_n, sel, en, wr, rdy, err, cen, cwr, e;
  logic [3:0]   drst_n, dsel, msel, crst_n, crdy;
  logic [14:0]  addr;
  logic [31:0]  wd, rd, cwd, q, lastw;
  logic [11:0]  off;
  logic [127:0] crd;
  logic [1:0]   wait_cnt;
  int           bad_count, checks;

  dad_decoder #(.NUM_CORES(4)) u_dad_decoder (.clk(clk), .reset_n(reset_n),
    .debug_logic_reset_n(drst_n), .debug_port_select(sel), .penable(en), .pwrite(wr),
    .debug_port_address(addr), .pwdata(wd), .prdata(rd), .pready(rdy), .pslverr(err),
    .core_dbg_sel(dsel), .core_mon_sel(msel), .comp_enable(cen), .comp_write(cwr),
    .comp_offset(off), .comp_wdata(cwd), .core_debug_reset_n(crst_n),
    .comp_rdata(crd), .comp_ready(crdy));
  dad_master u_dad_master (.clk(clk), .sel(sel), .en(en), .wr(wr), .addr(addr),
    .wdata(wd), .ready(rdy), .err(err), .rdata(rd));

  // slow components: two wait states, so pready must follow comp_ready
  always @(posedge clk) wait_cnt <= (en && !rdy) ? wait_cnt + 2'h1 : 2'h0;
  assign crdy = {4{wait_cnt == 2'h2}};
  // each component answers with its identity and the offset it saw
  for (genvar i = 0; i < 4; i++) begin : g_rsp
    assign crd[i*32 +: 32] = {11'h0, msel[i], 2'h0, 2'(i), 4'h0, off};
  end
  always @(posedge clk) if (cen && cwr && rdy) lastw <= cwd;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic t_reset;
    drst_n = 4'h6;
    @(negedge clk);
    chk({28'h0, crst_n}, 32'h6);
    drst_n = 4'hf;
  endtask

  task automatic t_idle;
    @(negedge clk);
    chk({24'h0, dsel, msel}, 32'h0);
  endtask

  task automatic t_decode;
    for (int c = 0; c < 4; c++)
      for (int m = 0; m < 2; m++) begin
        u_dad_master.xfer(1'b0, {c[1:0], m[0], 12'h0a5}, 32'h0, q, e);
        chk(q, {11'h0, m[0], 2'h0, c[1:0], 4'h0, 12'h0a5});
        chk({31'h0, e}, 32'h0);
      end
  endtask

  task automatic t_write;
    u_dad_master.xfer(1'b1, 15'h7fff, 32'h1234_5678, q, e);
    chk(lastw, 32'h1234_5678);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic complete_run;
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100_000;
    bad_count++;
    complete_run;
  end

  initial begin
    reset_n = 1'b0;
    drst_n = 4'hf;
    repeat (3) @(negedge clk);
    chk({28'h0, crst_n}, 32'h0);
    chk(rd, 32'h0);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_idle;
    t_decode;
    t_write;
    complete_run;
  end
endmodule
`default_nettype wire
